// *** mcu_interrupt_enable_flag_logic.sv ***
/*
 Interrupt enable and flag logic of a small microcontroller core: the
 interrupt control register, the first peripheral enable register, pin
 configuration and the combined request to the processor core.
 Assumes timer and peripheral event inputs are on clock_i, pins are
 asynchronous, and the core pulses take and return for one cycle.
*/
// Strobed register access and the placing of the registers were decided locally.
//
// Behaviour
// - Control bit 7 is the global enable; clear blocks every request.
// - Control bit 6 gates all peripheral sources onto the request.
// - Peripheral enables act only while the peripheral gate is set.
// - Flags set on their event whatever any enable holds.
// - Control bit 5 enables the timer-0 overflow interrupt.
// - Control bit 4 enables the external edge interrupt.
// - Control bit 3 enables port change; pins count only if unmasked.
// - Bit 2 sets on timer-0 overflow; only a software zero clears it.
// - Bit 1 sets on external edge; stays until software writes zero.
// - Bit 0 sets on any watched pin change; stays until cleared.
// - Every control bit, flags included, is readable and writable.
// - Eight peripheral enables, read/write, all zero after reset.
// - External edge is rising when select is set, else falling.
// - Taking an interrupt clears global enable and loads the vector.
// - Peripheral flags live in a separate register paired to enables.
`timescale 1ns/10ps
module mcu_interrupt_enable_flag_logic #(
   parameter int unsigned PORT_W = 8
) (
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   input  wire logic [2:0]        addr_i,
   input  wire logic [7:0]        wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [7:0]        rdata_o,
   input  wire logic              timer0_overflow_i,
   input  wire logic              external_irq_pin_i,
   input  wire logic [PORT_W-1:0] change_watch_port_i,
   input  wire logic [7:0]        peripheral_irq_flags_one_i,
   input  wire logic              irq_take_i,
   input  wire logic              irq_return_i,
   output logic                   irq_request_o,
   output logic                   vector_load_o,
   output logic      [15:0]       vector_addr_o
);

   // Interrupt control state
   logic              global_irq_enable;
   logic              peripheral_irq_gate;
   logic              timer0_overflow_irq_enable;
   logic              ext_pin_irq_enable;
   logic              port_change_irq_enable;
   logic              timer0_overflow_flag;
   logic              ext_pin_irq_flag;
   logic              port_change_flag;
   logic [7:0]        peripheral_irq_enable_one;
   logic [PORT_W-1:0] pin_change_enable_mask;
   logic              ext_edge_select;

   logic [7:0]        interrupt_control;
   logic [7:0]        next_rdata;
   logic [PORT_W:0]   pins_sync;
   logic              core_pending;
   logic              periph_pending;
   logic              wr_ctrl;
   logic              take_ok;

   pin_event_if #(.PORT_W(PORT_W)) pev ();

   function automatic logic reg_hit(input logic [2:0] a,
                                    input logic [2:0] off);
      reg_hit = (a == off);
   endfunction

   // Pins are asynchronous, so both pass two flip-flops first
   pin_synchroniser #(
      .WIDTH (PORT_W + 1)
   ) u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i ({external_irq_pin_i, change_watch_port_i}),
      .sync_o  (pins_sync)
   );

   assign pev.ext_level   = pins_sync[PORT_W];
   assign pev.port_level  = pins_sync[PORT_W-1:0];
   assign pev.edge_select = ext_edge_select;
   assign pev.change_mask = pin_change_enable_mask;

   pin_event_detect #(
      .PORT_W (PORT_W)
   ) u_detect (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .ev      (pev.detector)
   );

   assign wr_ctrl = wr_i && reg_hit(addr_i,
                                    mcu_irq_pkg::OFF_INTERRUPT_CONTROL);
   assign take_ok = irq_take_i && global_irq_enable;

   // Global enable: the core's take beats a software write that cycle
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         global_irq_enable <=
            mcu_irq_pkg::INTERRUPT_CONTROL_RESET[mcu_irq_pkg::BIT_GLOBAL_EN];
      end else if (take_ok) begin
         global_irq_enable <= 1'b0;
      end else if (wr_ctrl) begin
         global_irq_enable <= wdata_i[mcu_irq_pkg::BIT_GLOBAL_EN];
      end else if (irq_return_i) begin
         global_irq_enable <= 1'b1;
      end
   end

   // Remaining enables of the control register
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         peripheral_irq_gate        <= 1'b0;
         timer0_overflow_irq_enable <= 1'b0;
         ext_pin_irq_enable         <= 1'b0;
         port_change_irq_enable     <= 1'b0;
      end else if (wr_ctrl) begin
         peripheral_irq_gate <= wdata_i[mcu_irq_pkg::BIT_PERIPH_GATE];
         timer0_overflow_irq_enable <=
            wdata_i[mcu_irq_pkg::BIT_T0_EN];
         ext_pin_irq_enable <= wdata_i[mcu_irq_pkg::BIT_EXT_EN];
         port_change_irq_enable <= wdata_i[mcu_irq_pkg::BIT_CHG_EN];
      end
   end

   // Flags: a write stores the bit, an event in the same cycle still sets
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         timer0_overflow_flag <= 1'b0;
         ext_pin_irq_flag     <= 1'b0;
         port_change_flag     <= 1'b0;
      end else begin
         timer0_overflow_flag <= (wr_ctrl ?
            wdata_i[mcu_irq_pkg::BIT_T0_FLAG] : timer0_overflow_flag)
            | timer0_overflow_i;
         ext_pin_irq_flag <= (wr_ctrl ?
            wdata_i[mcu_irq_pkg::BIT_EXT_FLAG] : ext_pin_irq_flag)
            | pev.ext_event;
         port_change_flag <= (wr_ctrl ?
            wdata_i[mcu_irq_pkg::BIT_CHG_FLAG] : port_change_flag)
            | pev.change_event;
      end
   end

   // Peripheral enables
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         peripheral_irq_enable_one <= mcu_irq_pkg::PERIPH_ENABLE_RESET;
      end else if (wr_i && reg_hit(addr_i,
                                   mcu_irq_pkg::OFF_PERIPH_ENABLE_ONE)) begin
         peripheral_irq_enable_one <= wdata_i;
      end
   end

   // Pin configuration: change mask and edge select
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pin_change_enable_mask <= PORT_W'(mcu_irq_pkg::PIN_CHANGE_MASK_RESET);
         ext_edge_select        <= mcu_irq_pkg::EDGE_SELECT_RESET;
      end else begin
         if (wr_i && reg_hit(addr_i, mcu_irq_pkg::OFF_PIN_CHANGE_MASK)) begin
            pin_change_enable_mask <= wdata_i[PORT_W-1:0];
         end
         if (wr_i && reg_hit(addr_i, mcu_irq_pkg::OFF_PIN_CONFIG)) begin
            ext_edge_select <= wdata_i[mcu_irq_pkg::BIT_EDGE_SELECT];
         end
      end
   end

   // Vector load towards the core
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         vector_load_o <= 1'b0;
         vector_addr_o <= mcu_irq_pkg::VECTOR_IDLE;
      end else begin
         vector_load_o <= take_ok;
         if (take_ok) begin
            vector_addr_o <= mcu_irq_pkg::IRQ_VECTOR;
         end
      end
   end

   assign interrupt_control = {global_irq_enable, peripheral_irq_gate,
                               timer0_overflow_irq_enable,
                               ext_pin_irq_enable, port_change_irq_enable,
                               timer0_overflow_flag, ext_pin_irq_flag,
                               port_change_flag};

   // Request combination
   assign core_pending =
      (timer0_overflow_irq_enable && timer0_overflow_flag) ||
      (ext_pin_irq_enable && ext_pin_irq_flag) ||
      (port_change_irq_enable && port_change_flag);
   assign periph_pending = peripheral_irq_gate &&
      (|(peripheral_irq_enable_one & peripheral_irq_flags_one_i));
   assign irq_request_o = global_irq_enable &&
      (core_pending || periph_pending);

   // Read multiplexer; unmapped offsets read as zero
   always_comb begin
      unique case (addr_i)
         mcu_irq_pkg::OFF_INTERRUPT_CONTROL:
            next_rdata = interrupt_control;
         mcu_irq_pkg::OFF_PERIPH_ENABLE_ONE:
            next_rdata = peripheral_irq_enable_one;
         mcu_irq_pkg::OFF_PERIPH_FLAGS_ONE:
            next_rdata = peripheral_irq_flags_one_i;
         mcu_irq_pkg::OFF_PIN_CHANGE_MASK:
            next_rdata = 8'(pin_change_enable_mask);
         mcu_irq_pkg::OFF_PIN_CONFIG: begin
            next_rdata = mcu_irq_pkg::READ_IDLE;
            next_rdata[mcu_irq_pkg::BIT_EDGE_SELECT] = ext_edge_select;
         end
         default:
            next_rdata = mcu_irq_pkg::READ_IDLE;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdata_o <= mcu_irq_pkg::READ_IDLE;
      end else begin
         rdata_o <= rd_i ? next_rdata : mcu_irq_pkg::READ_IDLE;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   property p_global_block;
      !global_irq_enable |-> !irq_request_o;
   endproperty
   a_global_block: assert property (p_global_block)
      else $error("Request raised with global enable clear");

   property p_periph_gate;
      (!peripheral_irq_gate && !core_pending) |-> !irq_request_o;
   endproperty
   a_periph_gate: assert property (p_periph_gate)
      else $error("Peripheral request passed a closed gate");

   property p_periph_path;
      (global_irq_enable && peripheral_irq_gate &&
       (|(peripheral_irq_enable_one & peripheral_irq_flags_one_i)))
      |-> irq_request_o;
   endproperty
   a_periph_path: assert property (p_periph_path)
      else $error("Enabled peripheral flag gave no request");

   property p_flag_ignores_enable;
      (timer0_overflow_i && !timer0_overflow_irq_enable &&
       !global_irq_enable) |=> timer0_overflow_flag;
   endproperty
   a_flag_ignores_enable: assert property (p_flag_ignores_enable)
      else $error("Flag not set while its enable was clear");

   property p_t0_request;
      (global_irq_enable && timer0_overflow_irq_enable &&
       timer0_overflow_flag) |-> irq_request_o;
   endproperty
   a_t0_request: assert property (p_t0_request)
      else $error("Timer-0 pair set but no request");

   property p_ext_request;
      (global_irq_enable && ext_pin_irq_enable && ext_pin_irq_flag)
      |-> irq_request_o;
   endproperty
   a_ext_request: assert property (p_ext_request)
      else $error("External pair set but no request");

   property p_t0_sticky;
      (timer0_overflow_flag && !wr_ctrl) |=> timer0_overflow_flag;
   endproperty
   a_t0_sticky: assert property (p_t0_sticky)
      else $error("Timer-0 flag dropped without a write");

   property p_t0_set_wins;
      (wr_ctrl && !wdata_i[mcu_irq_pkg::BIT_T0_FLAG] && timer0_overflow_i)
      |=> timer0_overflow_flag;
   endproperty
   a_t0_set_wins: assert property (p_t0_set_wins)
      else $error("Overflow lost against a clearing write");

   property p_ext_flag;
      pev.ext_event |=> ext_pin_irq_flag [*2] or
         (ext_pin_irq_flag ##1 $past(wr_ctrl));
   endproperty
   a_ext_flag: assert property (p_ext_flag)
      else $error("External flag not set by edge");

   property p_change_flag;
      pev.change_event |=> port_change_flag;
   endproperty
   a_change_flag: assert property (p_change_flag)
      else $error("Port change flag not set by change");

   property p_change_sticky;
      (port_change_flag && !wr_ctrl) |=> port_change_flag;
   endproperty
   a_change_sticky: assert property (p_change_sticky)
      else $error("Port change flag dropped without a write");

   property p_ext_sticky;
      (ext_pin_irq_flag && !wr_ctrl) |=> ext_pin_irq_flag;
   endproperty
   a_ext_sticky: assert property (p_ext_sticky)
      else $error("External flag dropped without a write");

   property p_read_ctrl;
      (rd_i && reg_hit(addr_i, mcu_irq_pkg::OFF_INTERRUPT_CONTROL) &&
       !wr_i) |=> (rdata_o == $past(interrupt_control)) ##1
       (rdata_o == mcu_irq_pkg::READ_IDLE || $past(rd_i));
   endproperty
   a_read_ctrl: assert property (p_read_ctrl)
      else $error("Control read returned wrong data");

   property p_pie_write;
      (wr_i && reg_hit(addr_i, mcu_irq_pkg::OFF_PERIPH_ENABLE_ONE))
      |=> peripheral_irq_enable_one == $past(wdata_i);
   endproperty
   a_pie_write: assert property (p_pie_write)
      else $error("Peripheral enable write not stored");

   property p_take;
      take_ok |=> (!global_irq_enable && vector_load_o &&
                   vector_addr_o == mcu_irq_pkg::IRQ_VECTOR) ##1
                  !vector_load_o || $past(take_ok);
   endproperty
   a_take: assert property (p_take)
      else $error("Interrupt take did not clear enable or load vector");

   cover property (take_ok);
   cover property (pev.ext_event && ext_pin_irq_enable);
   cover property (periph_pending && global_irq_enable);
   cover property (wr_ctrl && timer0_overflow_i);

endmodule

// *** mcu_irq_pkg.sv ***
/*
 Constants shared by the interrupt enable and flag logic: register
 offsets, bit positions, values after reset and the vector address.
 Assumes an 8-bit register port with a 3-bit word address.
*/
package mcu_irq_pkg;

   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [2:0] OFF_INTERRUPT_CONTROL   = 3'h0;
   localparam logic [2:0] OFF_PERIPH_ENABLE_ONE   = 3'h1;
   localparam logic [2:0] OFF_PERIPH_FLAGS_ONE    = 3'h2;
   localparam logic [2:0] OFF_PIN_CHANGE_MASK     = 3'h3;
   localparam logic [2:0] OFF_PIN_CONFIG          = 3'h4;

   // Interrupt control bit positions
   localparam int unsigned BIT_GLOBAL_EN    = 7;
   localparam int unsigned BIT_PERIPH_GATE  = 6;
   localparam int unsigned BIT_T0_EN        = 5;
   localparam int unsigned BIT_EXT_EN       = 4;
   localparam int unsigned BIT_CHG_EN       = 3;
   localparam int unsigned BIT_T0_FLAG      = 2;
   localparam int unsigned BIT_EXT_FLAG     = 1;
   localparam int unsigned BIT_CHG_FLAG     = 0;

   // Pin configuration bit position
   localparam int unsigned BIT_EDGE_SELECT  = 6;

   // Values after reset
   localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
   localparam logic [7:0] PERIPH_ENABLE_RESET     = 8'h00;
   localparam logic [7:0] PIN_CHANGE_MASK_RESET   = 8'h00;
   localparam logic       EDGE_SELECT_RESET       = 1'b1;
   localparam logic [7:0] READ_IDLE               = 8'h00;

   // Address loaded into the program counter on an accepted interrupt
   localparam logic [15:0] IRQ_VECTOR             = 16'h0004;
   localparam logic [15:0] VECTOR_IDLE            = 16'h0000;

endpackage

// *** pin_event_if.sv ***
/*
 Carrier between the top level and the pin event detector: synchronised
 pin levels and settings in, event pulses out.
 Assumes all signals live on the single system clock.
*/
`timescale 1ns/10ps
interface pin_event_if #(parameter int unsigned PORT_W = 8);
   logic              ext_level;
   logic              edge_select;
   logic [PORT_W-1:0] port_level;
   logic [PORT_W-1:0] change_mask;
   logic              ext_event;
   logic              change_event;

   modport detector (
      input  ext_level,
      input  edge_select,
      input  port_level,
      input  change_mask,
      output ext_event,
      output change_event
   );

   modport owner (
      output ext_level,
      output edge_select,
      output port_level,
      output change_mask,
      input  ext_event,
      input  change_event
   );
endinterface

// *** pin_synchroniser.sv ***
/*
 Two-stage synchroniser for a group of asynchronous pins.
 Assumes each bit is an independent level; no bus coherence is kept.
*/
`timescale 1ns/10ps
module pin_synchroniser #(
   parameter int unsigned WIDTH = 9
) (
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// *** pin_event_detect.sv ***
/*
 Edge detector for the external interrupt pin and change detector for the
 watched port. Inputs must already be synchronised to clock_i.
*/
`timescale 1ns/10ps
module pin_event_detect #(
   parameter int unsigned PORT_W = 8
) (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   pin_event_if.detector ev
);
   logic              ext_prev;
   logic [PORT_W-1:0] port_prev;
   logic [2:0]        prime_pipe;
   logic              primed;

   // Prev is stale until the synchroniser carries a real pin level, so
   // events stay masked for three edges; a pin high at reset is no edge
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ext_prev   <= 1'b0;
         port_prev  <= '0;
         prime_pipe <= 3'h0;
      end else begin
         ext_prev   <= ev.ext_level;
         port_prev  <= ev.port_level;
         prime_pipe <= {prime_pipe[1:0], 1'b1};
      end
   end

   assign primed = prime_pipe[2];

   assign ev.ext_event = primed && (ev.edge_select ?
                         (ev.ext_level && !ext_prev) :
                         (!ev.ext_level && ext_prev));
   assign ev.change_event = primed &&
      (|((ev.port_level ^ port_prev) & ev.change_mask));

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   property p_rise_select;
      (primed && ev.edge_select && $rose(ev.ext_level)) |-> ev.ext_event;
   endproperty
   a_rise_select: assert property (p_rise_select)
      else $error("Rising edge missed with rising select");

   property p_masked_change;
      (ev.port_level & ev.change_mask) == (port_prev & ev.change_mask)
      |-> !ev.change_event;
   endproperty
   a_masked_change: assert property (p_masked_change)
      else $error("Change event from a masked pin");
endmodule

// *** irq_core_model.sv ***
/*
 Behavioural processor core facing the interrupt logic: it takes a
 pending request after a chosen latency and returns from service when
 the bench says so.
 Assumes the single system clock and one-cycle take and return pulses.
*/
`timescale 1ns/10ps
module irq_core_model (
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic       irq_request_i,
   input  wire logic       take_enable_i,
   input  wire logic [1:0] take_latency_i,
   input  wire logic       service_done_i,
   output logic            irq_take_o,
   output logic            irq_return_o
);
   logic [1:0] wait_count;
   logic       due;

   assign due = (wait_count == take_latency_i);

   // Slow latency lets the request stand a few cycles before the take
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wait_count <= 2'h0;
         irq_take_o <= 1'b0;
      end else if (take_enable_i && irq_request_i && !irq_take_o) begin
         irq_take_o <= due;
         wait_count <= due ? 2'h0 : wait_count + 2'h1;
      end else begin
         wait_count <= 2'h0;
         irq_take_o <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      irq_return_o <= rst_n_i & service_done_i;
   end
endmodule

// *** mcu_interrupt_enable_flag_logic_bench.sv ***
/*
 Self-checking bench for the interrupt enable and flag logic, with a
 core model answering requests.
 Assumes the package offsets and reset values of the design.
*/
`timescale 1ns/10ps
module mcu_interrupt_enable_flag_logic_bench;
   localparam logic [2:0] CTL = mcu_irq_pkg::OFF_INTERRUPT_CONTROL;
   localparam logic [2:0] PEN = mcu_irq_pkg::OFF_PERIPH_ENABLE_ONE;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [2:0]  addr_i = 3'h0;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        t0_ovf = 1'b0;
   logic        ext_pin = 1'b0;
   logic [7:0]  watch_port = 8'h00;
   logic [7:0]  periph_flags = 8'h00;
   logic        take_enable = 1'b0;
   logic [1:0]  take_latency = 2'h0;
   logic        service_done = 1'b0;
   logic [7:0]  rdata_o;
   logic        irq_take;
   logic        irq_return;
   logic        irq_request_o;
   logic        vector_load_o;
   logic [15:0] vector_addr_o;
   logic [7:0]  rd_val;
   logic [7:0]  en_tab [3] = '{8'h20, 8'h10, 8'h08};
   logic [7:0]  fl_tab [3] = '{8'h04, 8'h02, 8'h01};
   int          num_errors = 0;
   int          samples_checked = 0;

   always #20 clock_i = ~clock_i;

   mcu_interrupt_enable_flag_logic u_dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .timer0_overflow_i(t0_ovf), .external_irq_pin_i(ext_pin),
      .change_watch_port_i(watch_port),
      .peripheral_irq_flags_one_i(periph_flags),
      .irq_take_i(irq_take), .irq_return_i(irq_return),
      .irq_request_o(irq_request_o), .vector_load_o(vector_load_o),
      .vector_addr_o(vector_addr_o)
   );

   irq_core_model u_core (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .irq_request_i(irq_request_o),
      .take_enable_i(take_enable), .take_latency_i(take_latency),
      .service_done_i(service_done), .irq_take_o(irq_take),
      .irq_return_o(irq_return)
   );

   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic fail(input string msg);
      num_errors++;
      $display("ERROR at %0t: %s", $time, msg);
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) fail($sformatf("reg got %h exp %h", got, exp));
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) fail($sformatf("bit got %b exp %b", got, exp));
   endtask

   task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) fail($sformatf("vector got %h exp %h", got, exp));
   endtask

   task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic reg_expect(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      rd_val = rdata_o;
      chk_reg(rd_val, exp);
   endtask

   // Pin levels pass a two-flop synchroniser, so allow the settle time
   task automatic set_pins(input logic pin, input logic [7:0] port);
      @(posedge clock_i);
      ext_pin <= pin;
      watch_port <= port;
      step(4);
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #2000000;
      fail("watchdog expired");
      give_verdict();
   end

   initial begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      step(2);
      reg_expect(CTL, mcu_irq_pkg::INTERRUPT_CONTROL_RESET);
      reg_expect(mcu_irq_pkg::OFF_PIN_CONFIG, 8'h40);
      reg_expect(mcu_irq_pkg::OFF_PIN_CHANGE_MASK,
                 mcu_irq_pkg::PIN_CHANGE_MASK_RESET);
      reg_expect(PEN, mcu_irq_pkg::PERIPH_ENABLE_RESET);
      reg_expect(3'h5, mcu_irq_pkg::READ_IDLE);
      chk_bit(irq_request_o, 1'b0);
      $display("test reset done");

      reg_write(CTL, 8'h7F);
      reg_expect(CTL, 8'h7F);
      chk_bit(irq_request_o, 1'b0);
      reg_write(CTL, 8'h80);
      reg_expect(CTL, 8'h80);
      reg_write(CTL, 8'h00);
      for (int i = 0; i < 8; i++) begin
         reg_write(PEN, 8'h01 << i);
         reg_expect(PEN, 8'h01 << i);
      end
      @(posedge clock_i);
      periph_flags <= 8'hA5;
      reg_write(mcu_irq_pkg::OFF_PERIPH_FLAGS_ONE, 8'h00);
      reg_expect(mcu_irq_pkg::OFF_PERIPH_FLAGS_ONE, 8'hA5);
      $display("test register access done");

      @(posedge clock_i);
      t0_ovf <= 1'b1;
      @(posedge clock_i);
      t0_ovf <= 1'b0;
      step(1);
      reg_expect(CTL, 8'h04);
      step(20);
      reg_expect(CTL, 8'h04);
      chk_bit(irq_request_o, 1'b0);
      // Timer counter lives outside; the flag is cleared by a software write of zero
      reg_write(CTL, 8'h00);
      reg_expect(CTL, 8'h00);
      $display("test timer flag done");

      set_pins(1'b1, 8'h00);
      reg_expect(CTL, 8'h02);
      reg_write(CTL, 8'h00);
      set_pins(1'b0, 8'h00);
      reg_expect(CTL, 8'h00);
      reg_write(mcu_irq_pkg::OFF_PIN_CONFIG, 8'h00);
      reg_expect(mcu_irq_pkg::OFF_PIN_CONFIG, 8'h00);
      set_pins(1'b1, 8'h00);
      reg_expect(CTL, 8'h00);
      set_pins(1'b0, 8'h00);
      reg_expect(CTL, 8'h02);
      reg_write(CTL, 8'h00);
      set_pins(1'b0, 8'h01);
      reg_expect(CTL, 8'h00);
      reg_write(mcu_irq_pkg::OFF_PIN_CHANGE_MASK, 8'h02);
      reg_expect(mcu_irq_pkg::OFF_PIN_CHANGE_MASK, 8'h02);
      set_pins(1'b0, 8'h03);
      reg_expect(CTL, 8'h01);
      reg_write(CTL, 8'h00);
      set_pins(1'b0, 8'h02);
      reg_expect(CTL, 8'h00);
      $display("test pin events done");

      for (int i = 0; i < 3; i++) begin
         reg_write(CTL, en_tab[i] | fl_tab[i]);
         chk_bit(irq_request_o, 1'b0);
         reg_write(CTL, 8'h80 | en_tab[i] | fl_tab[i]);
         chk_bit(irq_request_o, 1'b1);
         reg_write(CTL, 8'h80 | fl_tab[i]);
         chk_bit(irq_request_o, 1'b0);
         reg_write(CTL, 8'h80 | en_tab[i] | fl_tab[(i + 1) % 3]);
         chk_bit(irq_request_o, 1'b0);
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge clock_i);
         periph_flags <= 8'h01 << i;
         reg_write(PEN, 8'h01 << i);
         reg_write(CTL, 8'h80);
         chk_bit(irq_request_o, 1'b0);
         reg_write(CTL, 8'hC0);
         chk_bit(irq_request_o, 1'b1);
         reg_write(PEN, ~(8'h01 << i));
         chk_bit(irq_request_o, 1'b0);
         reg_write(CTL, 8'h00);
      end
      $display("test request gating done");

      for (int k = 0; k < 2; k++) begin
         @(posedge clock_i);
         take_latency <= (k == 0) ? 2'h0 : 2'h3;
         take_enable <= 1'b1;
         reg_write(CTL, 8'h20);
         reg_write(CTL, 8'hA0);
         @(posedge clock_i);
         t0_ovf <= 1'b1;
         @(posedge clock_i);
         t0_ovf <= 1'b0;
         for (int n = 0; n < 20 && vector_load_o !== 1'b1; n++) step(1);
         chk_bit(vector_load_o, 1'b1);
         chk_vec(vector_addr_o, mcu_irq_pkg::IRQ_VECTOR);
         chk_bit(irq_request_o, 1'b0);
         step(1);
         chk_bit(vector_load_o, 1'b0);
         @(posedge clock_i);
         take_enable <= 1'b0;
         reg_expect(CTL, 8'h24);
         reg_write(CTL, 8'h20);
         @(posedge clock_i);
         service_done <= 1'b1;
         @(posedge clock_i);
         service_done <= 1'b0;
         step(2);
         reg_expect(CTL, 8'hA0);
         chk_bit(irq_request_o, 1'b0);
         reg_write(CTL, 8'h00);
      end
      $display("test core take done");
      give_verdict();
   end
endmodule
